// ==== hdl/wb_defs.svh ====
`ifndef WB_DEFS_SVH
`define WB_DEFS_SVH
// Device control register and its fields.
`define WB_CTRL_ADDR 8'h2A
`define WB_CTRL_RESET 8'h00
`define WB_PAGE_MSB 7
`define WB_PAGE_LSB 6
`define WB_EN_BIT 5
`define WB_RELOAD_BIT 4
// Table geometry and the size of the initial load.
`define WB_ENTRIES 256
`define WB_INIT_WRITES 10'h300
`define WB_LAST_ENTRY 8'hFF
// Host register offsets on APB.
`define WB_HOST_CMD 12'h000
`define WB_HOST_CFG 12'h004
`define WB_HOST_STAT 12'h008
// Host command and configuration register fields.
`define WB_CMD_WRITE_BIT 18
`define WB_CFG_EN_BIT 0
`define WB_CFG_RELOAD_BIT 1
`endif

// ==== hdl/wb_pkg.sv ====
`default_nettype none
package wb_pkg;
  // Page selected by the control register page field.
  typedef enum logic [1:0] {
    WB_PAGE_CFG = 2'h0,
    WB_PAGE_RED = 2'h1,
    WB_PAGE_GREEN = 2'h2,
    WB_PAGE_BLUE = 2'h3
  } wb_page_t;
  // Device access handler states.
  typedef enum logic [2:0] {
    WB_DEV_IDLE = 3'h1,
    WB_DEV_READ = 3'h2,
    WB_DEV_DONE = 3'h4
  } wb_dev_state_t;
  // Host sequencer states.
  typedef enum logic [3:0] {
    WB_HOST_IDLE = 4'h1,
    WB_HOST_PLAN = 4'h2,
    WB_HOST_CTRL = 4'h4,
    WB_HOST_XFER = 4'h8
  } wb_host_state_t;
endpackage
`default_nettype wire

// ==== hdl/wb_ctl_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Register access channel between the host controller and the device.
interface wb_ctl_if;
  logic req; // Request held until ack.
  logic we; // High for a write.
  logic [7:0] addr; // Register or entry address within the page.
  logic [7:0] wdata; // Write data.
  logic ctrl_sel; // Access goes to the control page whatever page is set.
  logic ack; // One-cycle answer pulse.
  logic err; // Write was not carried out, valid with ack.
  logic [7:0] rdata; // Read data, valid with ack.
  modport host (output req, we, addr, wdata, ctrl_sel, input ack, err, rdata);
  modport dev (input req, we, addr, wdata, ctrl_sel, output ack, err, rdata);
endinterface
`default_nettype wire

// ==== hdl/wb_lut_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
// One colour table with a write port and two synchronous read ports.
module wb_lut_ram #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8,
  parameter int DEPTH = 256
) (
  input wire logic pclk, // Pixel clock.
  input wire logic we, // Write strobe.
  input wire logic [ADDR_W-1:0] waddr, // Write address.
  input wire logic [DATA_W-1:0] wdata, // Write data.
  input wire logic [ADDR_W-1:0] raddr_a, // Pixel lookup address.
  output logic [DATA_W-1:0] rdata_a, // Pixel lookup data.
  input wire logic [ADDR_W-1:0] raddr_b, // Readback address.
  output logic [DATA_W-1:0] rdata_b // Readback data.
);
  // Table storage; it has no defined contents after reset.
  logic [DATA_W-1:0] mem [DEPTH];

  // Reads return the old entry when a write hits the same edge, so a pixel
  // never sees a half written value.
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule
`default_nettype wire

// ==== hdl/wb_device.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "wb_defs.svh"
// What this block does
// - Host loads all three tables before enabling.
// - Initial load order is red, green, blue.
// - Tables hold 256 eight-bit entries, all loaded.
// - Control bits 7:6 select the addressed page.
// - Table writes refused after initial load.
// - Reload bit 4 permits later table writes.
// - Reloads apply without disturbing the pixel stream.
// - Partial reloads of entries are accepted.
// - Control bit 5 enables white balance.
// - Pages 1-3 expose readable, writable entries.
// - Enabled tables replace each subpixel value.
// - Host zeroes unused low bits of entries.
module wb_device #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 256
) (
  input wire logic pclk, // Pixel clock.
  input wire logic presetn, // Asynchronous reset, active low.
  wb_ctl_if.dev ctl, // Register access from the host.
  input wire logic pix_valid, // Input pixel valid.
  input wire logic [DATA_W-1:0] pix_red, // Input red subpixel.
  input wire logic [DATA_W-1:0] pix_green, // Input green subpixel.
  input wire logic [DATA_W-1:0] pix_blue, // Input blue subpixel.
  output logic out_valid, // Output pixel valid.
  output logic [DATA_W-1:0] out_red, // Output red subpixel.
  output logic [DATA_W-1:0] out_green, // Output green subpixel.
  output logic [DATA_W-1:0] out_blue, // Output blue subpixel.
  output logic init_done // Initial table load complete.
);
  wb_pkg::wb_dev_state_t state; // Access handler state.
  logic [7:0] ctrl; // Control register, low nibble reads as zero.
  logic [9:0] init_cnt; // Accepted table writes during the initial load.
  logic [1:0] rd_page; // Page latched for a pending read.
  logic [DATA_W-1:0] tab_q_pix [3]; // Table outputs for the pixel path.
  logic [DATA_W-1:0] tab_q_reg [3]; // Table outputs for readback.
  logic [DATA_W-1:0] pix_in [3]; // Input subpixels by colour.
  logic [DATA_W-1:0] s1_pix [3]; // Delayed input subpixels.
  logic s1_valid; // Delayed input valid.
  logic s1_en; // Enable captured with the pixel.

  // Access decode.
  wire [1:0] page = ctrl[`WB_PAGE_MSB:`WB_PAGE_LSB];
  wire take = (state == wb_pkg::WB_DEV_IDLE) && ctl.req;
  // The select line keeps the control register reachable from a table page;
  // without it a table page would hide the page field for good.
  wire to_cfg = (page == wb_pkg::WB_PAGE_CFG) || ctl.ctrl_sel;
  wire ctrl_hit = to_cfg && (ctl.addr == `WB_CTRL_ADDR);
  wire wb_en = ctrl[`WB_EN_BIT];
  wire reload_en = ctrl[`WB_RELOAD_BIT];
  // Tables take writes during the initial load, and afterwards only with
  // reload enabled; single entries may be rewritten in any order.
  wire tab_open = !init_done || reload_en;
  wire tab_wr = take && ctl.we && !to_cfg && tab_open;
  wire ctrl_wr = take && ctl.we && ctrl_hit;
  wire refused = ctl.we && !ctrl_wr && !tab_wr;

  assign pix_in[0] = pix_red;
  assign pix_in[1] = pix_green;
  assign pix_in[2] = pix_blue;

  // One table per colour; page 1 is red, 2 green and 3 blue.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tab
      wire sel = (page == 2'(gi + 1));
      wb_lut_ram #(
        .DATA_W(DATA_W),
        .ADDR_W(8),
        .DEPTH(DEPTH)
      ) u_ram (
        .pclk(pclk),
        .we(tab_wr && sel),
        .waddr(ctl.addr),
        .wdata(ctl.wdata[DATA_W-1:0]),
        .raddr_a(pix_in[gi][7:0]),
        .rdata_a(tab_q_pix[gi]),
        .raddr_b(ctl.addr),
        .rdata_b(tab_q_reg[gi])
      );
    end
  endgenerate

  // Readback value for the page latched with the read.
  wire [7:0] rd_val = (rd_page == wb_pkg::WB_PAGE_CFG) ?
    (ctrl_hit ? ctrl : 8'h00) : 8'(tab_q_reg[rd_page - 2'h1]);

  // Control register; only the page, enable and reload bits are stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `WB_CTRL_RESET;
    end
    else if (ctrl_wr)
    begin
      ctrl <= {ctl.wdata[7:4], 4'h0};
    end
  end

  // Initial load progress: complete after 768 accepted table writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_cnt <= 10'h000;
      init_done <= 1'b0;
    end
    else if (tab_wr && !init_done)
    begin
      init_cnt <= init_cnt + 10'h001;
      init_done <= (init_cnt == `WB_INIT_WRITES - 10'h001);
    end
  end

  // Access handler: writes answer one cycle after being taken, reads two.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= wb_pkg::WB_DEV_IDLE;
      ctl.ack <= 1'b0;
      ctl.err <= 1'b0;
      ctl.rdata <= 8'h00;
      rd_page <= 2'h0;
    end
    else
    begin
      case (state)
        wb_pkg::WB_DEV_IDLE:
        begin
          // A write takes effect on this edge; a read waits for the tables.
          if (take && ctl.we)
          begin
            ctl.ack <= 1'b1;
            ctl.err <= refused;
            state <= wb_pkg::WB_DEV_DONE;
          end
          else if (take)
          begin
            rd_page <= to_cfg ? 2'h0 : page;
            state <= wb_pkg::WB_DEV_READ;
          end
        end
        wb_pkg::WB_DEV_READ:
        begin
          // Table data for the latched address is now valid.
          ctl.rdata <= rd_val;
          ctl.err <= 1'b0;
          ctl.ack <= 1'b1;
          state <= wb_pkg::WB_DEV_DONE;
        end
        wb_pkg::WB_DEV_DONE:
        begin
          // The old request is still visible here and must not be retaken.
          ctl.ack <= 1'b0;
          state <= wb_pkg::WB_DEV_IDLE;
        end
        default:
        begin
          ctl.ack <= 1'b0;
          state <= wb_pkg::WB_DEV_IDLE;
        end
      endcase
    end
  end

  // Pixel stage one: the tables are read while the input is delayed, and
  // the enable is captured with the pixel so that a change never splits it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_valid <= 1'b0;
      s1_en <= 1'b0;
      s1_pix <= '{default: '0};
    end
    else
    begin
      s1_valid <= pix_valid;
      s1_en <= wb_en;
      s1_pix <= pix_in;
    end
  end

  // Pixel stage two: remapped or passed through; the stream never stalls,
  // so reloads while enabled cost no pixels.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_red <= '0;
      out_green <= '0;
      out_blue <= '0;
    end
    else
    begin
      out_valid <= s1_valid;
      out_red <= s1_en ? tab_q_pix[0] : s1_pix[0];
      out_green <= s1_en ? tab_q_pix[1] : s1_pix[1];
      out_blue <= s1_en ? tab_q_pix[2] : s1_pix[2];
    end
  end
endmodule
`default_nettype wire

// ==== hdl/wb_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "wb_defs.svh"
// Host controller: takes orders over APB and drives the device channel.
module wb_host (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, always low.
  wb_ctl_if.host ctl // Device register channel.
);
  wb_pkg::wb_host_state_t state; // Sequencer state.
  logic [7:0] cmd_addr; // Entry or register address.
  logic [7:0] cmd_data; // Write data.
  logic [1:0] cmd_page; // Target page.
  logic cmd_write; // Command is a write.
  logic pend_cmd; // A command waits behind the page change.
  logic cfg_en; // Enable requested by software.
  logic cfg_reload; // Reload requested by software.
  logic [1:0] cfg_lsb; // Count of low entry bits forced to zero.
  logic [1:0] sh_page; // Page last set in the device.
  logic sh_en; // Enable last sent to the device.
  logic [1:0] init_tab; // Table expected next in the initial load.
  logic [7:0] init_idx; // Entry expected next in the initial load.
  logic init_done; // All three tables loaded.
  logic refused; // Last order was refused.
  logic [7:0] rd_data; // Last read result.

  // APB decode; writes take effect at the access edge.
  wire apb_wr = psel && penable && pready && pwrite;
  wire idle = (state == wb_pkg::WB_HOST_IDLE);
  wire wr_cmd = apb_wr && idle && (paddr == `WB_HOST_CMD);
  wire wr_cfg = apb_wr && idle && (paddr == `WB_HOST_CFG);
  wire [1:0] new_page = pwdata[17:16];
  wire new_we = pwdata[`WB_CMD_WRITE_BIT];
  // Before loading ends, writes must hit the next entry of the next table.
  wire order_bad = !init_done && ((new_page != init_tab + 2'h1) ||
    (pwdata[7:0] != init_idx));
  wire cmd_bad = new_we && ((new_page == wb_pkg::WB_PAGE_CFG) || order_bad ||
    (init_done && !cfg_reload));
  wire [7:0] lsb_mask = 8'hFF << cfg_lsb;
  wire [1:0] ctrl_page = pend_cmd ? cmd_page : sh_page;
  // Enable is withheld until the tables are complete.
  wire ctrl_en = cfg_en && init_done;
  wire [7:0] ctrl_byte = {ctrl_page, ctrl_en, cfg_reload, 4'h0};
  wire [31:0] stat = {6'h00, init_tab, init_idx, rd_data, 4'h0, sh_en,
    refused, init_done, !idle};
  wire [31:0] rd_mux = (paddr == `WB_HOST_CFG) ? {28'h000_0000, cfg_lsb,
    cfg_reload, cfg_en} : (paddr == `WB_HOST_STAT) ? stat : 32'h0000_0000;

  // APB answer: ready one cycle after setup, read data captured with it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      prdata <= rd_mux;
    end
  end

  // Sequencer and device channel.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= wb_pkg::WB_HOST_IDLE;
      {cmd_addr, cmd_data, cmd_page, cmd_write, pend_cmd} <= '0;
      {cfg_en, cfg_reload, cfg_lsb, sh_page, sh_en} <= '0;
      {init_tab, init_idx, init_done, refused, rd_data} <= '0;
      {ctl.req, ctl.we, ctl.addr, ctl.wdata, ctl.ctrl_sel} <= '0;
    end
    else
    begin
      case (state)
        wb_pkg::WB_HOST_IDLE:
        begin
          // Configuration writes always update the device control register.
          if (wr_cfg)
          begin
            cfg_en <= pwdata[`WB_CFG_EN_BIT];
            cfg_reload <= pwdata[`WB_CFG_RELOAD_BIT];
            cfg_lsb <= pwdata[3:2];
            pend_cmd <= 1'b0;
            state <= wb_pkg::WB_HOST_PLAN;
          end
          else if (wr_cmd && cmd_bad)
          begin
            refused <= 1'b1;
          end
          else if (wr_cmd)
          begin
            cmd_addr <= pwdata[7:0];
            cmd_data <= pwdata[15:8];
            cmd_page <= new_page;
            cmd_write <= new_we;
            pend_cmd <= 1'b1;
            refused <= 1'b0;
            state <= wb_pkg::WB_HOST_PLAN;
          end
        end
        wb_pkg::WB_HOST_PLAN:
        begin
          // Change page first when the command needs another one.
          ctl.req <= 1'b1;
          if (!pend_cmd || (cmd_page != sh_page))
          begin
            ctl.we <= 1'b1;
            ctl.ctrl_sel <= 1'b1;
            ctl.addr <= `WB_CTRL_ADDR;
            ctl.wdata <= ctrl_byte;
            state <= wb_pkg::WB_HOST_CTRL;
          end
          else
          begin
            ctl.we <= cmd_write;
            ctl.ctrl_sel <= 1'b0;
            ctl.addr <= cmd_addr;
            ctl.wdata <= cmd_data & lsb_mask;
            state <= wb_pkg::WB_HOST_XFER;
          end
        end
        wb_pkg::WB_HOST_CTRL:
        begin
          // Request stays up until the device answers.
          if (ctl.ack)
          begin
            sh_page <= ctl.wdata[`WB_PAGE_MSB:`WB_PAGE_LSB];
            sh_en <= ctl.wdata[`WB_EN_BIT];
            ctl.req <= 1'b0;
            state <= pend_cmd ? wb_pkg::WB_HOST_PLAN : wb_pkg::WB_HOST_IDLE;
          end
        end
        wb_pkg::WB_HOST_XFER:
        begin
          if (ctl.ack)
          begin
            ctl.req <= 1'b0;
            pend_cmd <= 1'b0;
            refused <= ctl.err;
            if (!cmd_write)
            begin
              rd_data <= ctl.rdata;
            end
            // Advance through red, green and blue, every entry in turn.
            if (cmd_write && !ctl.err && !init_done)
            begin
              init_idx <= init_idx + 8'h01;
              if (init_idx == `WB_LAST_ENTRY)
              begin
                init_tab <= init_tab + 2'h1;
                init_done <= (init_tab == 2'h2);
              end
            end
            state <= wb_pkg::WB_HOST_IDLE;
          end
        end
        default:
        begin
          ctl.req <= 1'b0;
          state <= wb_pkg::WB_HOST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== bench/wb_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// Watches the register channel that joins the host and the device.
module wb_sva (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic req, // Host request.
  input wire logic we, // Write when high.
  input wire logic [7:0] addr, // Address within the page.
  input wire logic [7:0] wdata, // Write data.
  input wire logic ctrl_sel, // Control page select.
  input wire logic ack, // Device answer.
  input wire logic err, // Write refused.
  input wire logic [7:0] rdata // Read data.
);
  logic [7:0] ctrl; // Shadow of the device control byte.
  logic [9:0] loads; // Table writes carried out, stops at the full load.
  wire logic pg0 = ctrl[7:6] == 2'h0; // Configuration page is open.
  wire logic wr_ok = ack && we && !err; // A write was carried out.
  wire logic cfg_acc = pg0 || ctrl_sel; // Access reaches the control page.
  // Mirrors the control byte and counts the initial load.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl <= 8'h00;
      loads <= 10'h000;
    end
    else
    begin
      if (wr_ok && cfg_acc && addr == 8'h2A)
        ctrl <= wdata;
      if (wr_ok && !cfg_acc && loads != 10'h300)
        loads <= loads + 10'h001;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("Answer lasted more than one cycle.");
  ack_req_a: assert property (ack |-> req)
    else $error("Answer without a pending request.");
  req_hold_a: assert property (req && !ack |=> req && $stable(we) && $stable(addr) &&
    $stable(wdata) && $stable(ctrl_sel))
    else $error("Request changed before its answer.");
  req_drop_a: assert property ($fell(req) |-> $past(ack))
    else $error("Request withdrawn without an answer.");
  wr_time_a: assert property ($rose(req) && we |=> ack)
    else $error("Write not answered in one cycle.");
  rd_time_a: assert property ($rose(req) && !we |=> !ack ##1 ack)
    else $error("Read not answered in two cycles.");
  rd_clean_a: assert property (ack && !we |-> !err)
    else $error("Read flagged as refused.");
  pg0_err_a: assert property (ack && we && cfg_acc && addr != 8'h2A |-> err)
    else $error("Write to an unused configuration address accepted.");
  ctrl_rd_a: assert property (ack && !we && cfg_acc && addr == 8'h2A |->
    rdata == {ctrl[7:4], 4'h0})
    else $error("Control byte read back wrong.");
  lock_a: assert property (ack && we && !cfg_acc && loads == 10'h300 && !ctrl[4] |-> err)
    else $error("Table write accepted with reload off.");
  reload_a: assert property (ack && we && !cfg_acc &&
    (loads != 10'h300 || ctrl[4]) |-> !err)
    else $error("Allowed table write refused.");
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Drives the host over APB and the device pixel path, and judges both.
module tb_top;
  logic pclk; // Clock.
  logic presetn; // Reset, active low.
  logic psel, penable, pwrite, pready, pslverr; // APB controls.
  logic [11:0] paddr; // APB address.
  logic [31:0] pwdata, prdata, rd; // APB data and last read word.
  logic pix_valid, out_valid, init_done; // Pixel flags.
  logic [7:0] pix_red, pix_green, pix_blue, out_red, out_green, out_blue; // Subpixels.
  int failures, compares; // Verdict counters.
  wb_ctl_if u_wb_ctl_if ();
  wb_host u_wb_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctl(u_wb_ctl_if));
  wb_device u_wb_device (.pclk(pclk), .presetn(presetn), .ctl(u_wb_ctl_if),
    .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
    .out_valid(out_valid), .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
    .init_done(init_done));
  wb_sva u_wb_sva (.pclk(pclk), .presetn(presetn), .req(u_wb_ctl_if.req),
    .we(u_wb_ctl_if.we), .addr(u_wb_ctl_if.addr), .wdata(u_wb_ctl_if.wdata),
    .ctrl_sel(u_wb_ctl_if.ctrl_sel),
    .ack(u_wb_ctl_if.ack), .err(u_wb_ctl_if.err), .rdata(u_wb_ctl_if.rdata));
  // Prints the verdict and ends the run.
  task automatic close_out;
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compares one result word.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Table contents chosen for the load.
  function automatic logic [7:0] lv(input int t, input int e);
    return 8'(e * 7 + t * 61);
  endfunction
  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      close_out();
    end
  endtask
  // Writes a host register, waits until idle, checks the refusal flag after a command write.
  task automatic op(input logic [11:0] a, input logic [31:0] v, input logic refused);
    int n;
    n = 0;
    apb(1'b1, a, v);
    do
    begin
      apb(1'b0, 12'h008, 32'h0000_0000);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 40);
    if (rd[0] !== 1'b0)
    begin
      failures++;
      close_out();
    end
    if (a == 12'h000)
      chk({31'h0, rd[2]}, {31'h0, refused});
  endtask
  // Builds a command word.
  function automatic logic [31:0] cw(input logic w, input int pg, input logic [7:0] d, input int a);
    return {13'h0, w, 2'(pg), d, 8'(a)};
  endfunction
  // Presents one pixel and checks the output two cycles on.
  task automatic px(input logic [7:0] r, g, b, er, eg, eb);
    @(posedge pclk);
    pix_red <= r;
    pix_green <= g;
    pix_blue <= b;
    @(posedge pclk);
    @(posedge pclk);
    #1;
    chk({7'h0, out_valid, out_red, out_green, out_blue}, {8'h01, er, eg, eb});
  endtask
  // Reset state and pass-through while disabled.
  task automatic t_reset;
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, pslverr}, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    px(8'h12, 8'h34, 8'h56, 8'h12, 8'h34, 8'h56);
    // A one-cycle gap in the input stream shows up two cycles later.
    @(posedge pclk);
    pix_valid <= 1'b0;
    @(posedge pclk);
    pix_valid <= 1'b1;
    @(posedge pclk);
    #1;
    chk({31'h0, out_valid}, 32'h0000_0000);
  endtask
  // Initial load: wrong order refused, then red, green, blue in full.
  task automatic t_load;
    op(12'h004, 32'h0000_0001, 1'b0);
    px(8'h03, 8'h04, 8'h05, 8'h03, 8'h04, 8'h05);
    op(12'h000, cw(1'b1, 3, 8'h11, 0), 1'b1);
    op(12'h000, cw(1'b1, 1, 8'h11, 1), 1'b1);
    op(12'h000, cw(1'b1, 0, 8'h11, 42), 1'b1);
    for (int t = 1; t < 4; t++)
      for (int e = 0; e < 256; e++)
        op(12'h000, cw(1'b1, t, lv(t, e), e), 1'b0);
    chk({31'h0, init_done}, 32'h0000_0001);
  endtask
  // Enabled remapping, then locked and reloaded tables.
  task automatic t_remap;
    op(12'h004, 32'h0000_0001, 1'b0);
    chk({31'h0, rd[3]}, 32'h0000_0001);
    for (int i = 0; i < 256; i += 51)
      px(8'(i), 8'(255 - i), 8'(i ^ 5), lv(1, i), lv(2, 255 - i), lv(3, i ^ 5));
    op(12'h000, cw(1'b1, 1, 8'hA5, 5), 1'b1);
    px(8'h05, 8'h07, 8'h00, lv(1, 5), lv(2, 7), lv(3, 0));
    op(12'h004, 32'h0000_0003, 1'b0);
    op(12'h000, cw(1'b1, 2, 8'h3C, 7), 1'b0);
    px(8'h05, 8'h07, 8'hFF, lv(1, 5), 8'h3C, lv(3, 255));
    op(12'h000, cw(1'b0, 2, 8'h00, 7), 1'b0);
    chk({24'h0, rd[15:8]}, 32'h0000_003C);
    op(12'h000, cw(1'b0, 3, 8'h00, 255), 1'b0);
    chk({24'h0, rd[15:8]}, {24'h0, lv(3, 255)});
    op(12'h000, cw(1'b0, 0, 8'h00, 42), 1'b0);
    chk({24'h0, rd[15:8]}, 32'h0000_0030);
    // One low entry bit forced to zero on a reloaded red entry.
    op(12'h004, 32'h0000_0007, 1'b0);
    op(12'h000, cw(1'b1, 1, 8'hFF, 9), 1'b0);
    px(8'h09, 8'h07, 8'hFF, 8'hFE, 8'h3C, lv(3, 255));
    op(12'h004, 32'h0000_0002, 1'b0);
    px(8'h05, 8'h07, 8'hFF, 8'h05, 8'h07, 8'hFF);
  endtask
  // Free-running clock.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pix_red, pix_green, pix_blue} = '0;
    pix_valid = 1'b1;
    failures = 0;
    compares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_load();
    t_remap();
    close_out();
  end
endmodule
`default_nettype wire
